// *** core/bia_bid_form.sv ***
`timescale 1ns/1ps
`default_nettype none
module bia_bid_form (
    input wire bia_pkg::bia_src_t src,
    input wire logic [7:0] mask0,
    input wire logic [7:0] mask1,
    input wire logic [7:0] prog0,
    input wire logic [7:0] prog1,
    input wire logic [1:0] cten,
    input wire logic [3:0][7:0] lvl,
    output logic [17:0][7:0] bids
);
    logic [1:0] ch;
    logic [7:0] m;
    logic [7:0] p;
    logic [1:0] rxf;
    logic [2:0] txf;

    // eighteen sources: rx 0..3, tx 4..7, break 8..11, change 12..15, timers 16..17
    always_comb begin
        bids = '0;
        ch = 2'b00;
        m = 8'h00;
        p = 8'h00;
        rxf = 2'b00;
        txf = 3'b000;
        for (int c = 0; c < bia_pkg::NCH; c++) begin
            ch = 2'(c);
            m = ch[1] ? mask1 : mask0;
            p = ch[1] ? prog1 : prog0;
            rxf = src.rx_count[c][3] ? 2'b11 : src.rx_count[c][2:1];
            txf = src.tx_free[c][3] ? 3'b111 : src.tx_free[c][2:0];
            // level 0 means bid while not empty / not full
            if (m[{ch[0], 2'b00}] && (src.rx_count[c] > {1'b0, lvl[c][2:0]})) begin
                bids[c] = {1'b1, rxf, src.rx_error[c], bia_pkg::ID_RX, ch};
            end
            if (m[{ch[0], 2'b01}] && (src.tx_free[c] > {1'b0, lvl[c][6:4]})) begin
                bids[4 + c] = {1'b0, txf, bia_pkg::ID_TX, ch};
            end
            if (m[{ch[0], 2'b10}] && src.brk[c]) begin
                bids[8 + c] = {p[7:5], bia_pkg::ID_BRK, ch};
            end
            if (m[{ch[0], 2'b11}] && src.cos[c]) begin
                bids[12 + c] = {p[4:2], bia_pkg::ID_COS, ch};
            end
        end
        if (cten[0] && src.ct_done[0]) begin
            bids[16] = {prog0[1:0], 1'b0, bia_pkg::ID_CT, 2'b00};
        end
        if (cten[1] && src.ct_done[1]) begin
            bids[17] = {prog1[1:0], 1'b0, bia_pkg::ID_CT, 2'b10};
        end
    end
endmodule : bia_bid_form
`default_nettype wire

// *** core/bia_pkg.sv ***
package bia_pkg;
    localparam int NSRC = 18;
    localparam int NCH = 4;
    localparam int BIDW = 8;

    // register offsets on the host bus
    localparam logic [5:0] OFF_CIR = 6'h10;
    localparam logic [5:0] OFF_ICW = 6'h11;
    localparam logic [5:0] OFF_IVEC = 6'h12;
    localparam logic [5:0] OFF_MASK0 = 6'h13;
    localparam logic [5:0] OFF_MASK1 = 6'h14;
    localparam logic [5:0] OFF_PROG0 = 6'h15;
    localparam logic [5:0] OFF_PROG1 = 6'h16;
    localparam logic [5:0] OFF_CTEN = 6'h17;
    localparam logic [5:0] OFF_LVL0 = 6'h18;
    localparam logic [5:0] OFF_GBCNT = 6'h1c;
    localparam logic [5:0] OFF_GCHAN = 6'h1d;
    localparam logic [5:0] OFF_GRX = 6'h1e;
    localparam logic [5:0] OFF_GTX = 6'h1f;
    localparam logic [5:0] OFF_UPDATE = 6'h2a;

    // field positions
    localparam int ICW_THR_LSB = 2;
    localparam int CH_LSB = 0;
    localparam logic [1:0] VEC_PLAIN = 2'b00;
    localparam logic [1:0] VEC_CHAN = 2'b01;
    localparam logic [1:0] VEC_TYPE = 2'b10;
    localparam logic [1:0] VEC_NONE = 2'b11;

    // fixed source identifiers (bits 4:2, or 3:2 where bit 4 is data)
    localparam logic [1:0] ID_RX = 2'b11;
    localparam logic [1:0] ID_TX = 2'b10;
    localparam logic [2:0] ID_BRK = 3'b100;
    localparam logic [2:0] ID_COS = 3'b001;
    localparam logic [2:0] ID_CT = 3'b101;

    // reset values
    localparam logic [7:0] CIR_RST = 8'h00;
    localparam logic [7:0] ICW_RST = 8'hfc;
    localparam logic [7:0] IVEC_RST = 8'h0f;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PROG_RST = 8'h00;
    localparam logic [7:0] LVL_RST = 8'h00;
    localparam logic [1:0] CTEN_RST = 2'b00;

    typedef struct packed {
        logic [3:0][3:0] rx_count;
        logic [3:0] rx_error;
        logic [3:0][3:0] tx_free;
        logic [3:0] brk;
        logic [3:0] cos;
        logic [1:0] ct_done;
    } bia_src_t;

    typedef struct packed {
        logic cen_n;
        logic rd_n;
        logic wr_n;
        logic iack_n;
        logic [5:0] addr;
        logic [7:0] data;
    } bia_bus_t;

    localparam logic [17:0] BUS_IDLE = 18'h3_c000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_IACK = 4'b1000
    } bia_state_t;
endpackage : bia_pkg

// *** core/bia_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module bia_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] dout_r;
    wire logic [W-1:0] agree = ~(s2_r ^ s3_r);

    // a bit changes only once the last two stages agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            dout_r <= RST;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout_r <= (dout_r & ~agree) | (s3_r & agree);
        end
    end

    assign dout = dout_r;
endmodule : bia_sync
`default_nettype wire

// *** core/bia_top.sv ***
// How it works
// - eighteen sources: four rx, four tx, four break, four change, two timers
// - each cycle winning bid is compared with threshold; interrupt only above it
// - threshold is six bits against bid bits 7:2; channel bits ignored
// - capture loads winning bid only on acknowledge or refresh command
// - bits 4:2 (3:2 for rx and tx, where bit 4 is data) name source type with fixed codes per source kind
// - rx bid: 1, count, error, id, channel; tx bid: 0, count, id, channel
// - break, change and timer bids take upper bits from programmable fields
// - the greatest bid value wins arbitration
// - identifier and channel bits are hardwired, not software writable
// - idle timer, empty rx and full tx never bid
// - equal upper bits: highest channel wins, channel D strongest
// - nonzero fill level setting holds off rx/tx bids until exceeded
// - per-half mask enables each rx, tx, break and change source's bidding; timers use their own enable bits
// - control bits 1:0 select the vector modification format
// - global rx read and tx write go to the captured channel
// - global count and channel reads are right justified views of capture
// - captured bid drives global decoding; vector modification uses the winning bid being captured in that cycle
// - write to 2Ah refreshes capture; host issues it when not acknowledging
// - request output alone never updates the capture register
// - acknowledge updates capture and, except with control bits 1:0 at 11, drives the vector onto the bus
`timescale 1ns/1ps
`default_nettype none
module bia_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cen_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [5:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    input wire logic interrupt_acknowledge_n,
    output logic interrupt_request_n_out,
    output logic interrupt_request_n_oe_n,
    input wire bia_pkg::bia_src_t src,
    input wire logic [3:0][7:0] rx_data,
    output logic [3:0] rx_pop,
    output logic [3:0] tx_push,
    output logic [7:0] tx_data,
    output logic [7:0] current_interrupt_capture
);
    function automatic logic [7:0] bid_max(input logic [7:0] a, input logic [7:0] b);
        bid_max = (a > b) ? a : b;
    endfunction : bid_max

    function automatic logic [3:0] ch_onehot(input logic [1:0] c);
        ch_onehot = 4'h1 << c;
    endfunction : ch_onehot

    function automatic logic [7:0] vec_mod(input logic [7:0] v, input logic [1:0] f,
                                           input logic [7:0] b);
        case (f)
            bia_pkg::VEC_CHAN: vec_mod = {v[7:2], b[1:0]};
            bia_pkg::VEC_TYPE: vec_mod = {v[7:5], b[4:0]};
            default: vec_mod = v;
        endcase
    endfunction : vec_mod

    // host pins cross into core_clk
    bia_pkg::bia_bus_t pin_bus;
    bia_pkg::bia_bus_t s_bus;
    assign pin_bus = {cen_n, rd_n, wr_n, interrupt_acknowledge_n, addr, data_in};

    bia_sync #(
        .W(18),
        .RST(bia_pkg::BUS_IDLE)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .din(pin_bus),
        .dout(s_bus)
    );

    logic [7:0] cir_r;
    logic [7:0] icw_r;
    logic [7:0] ivec_r;
    logic [7:0] mask0_r;
    logic [7:0] mask1_r;
    logic [7:0] prog0_r;
    logic [7:0] prog1_r;
    logic [1:0] cten_r;
    logic [3:0][7:0] lvl_r;
    logic [5:0] addr_r;
    logic [7:0] wdat_r;
    logic [7:0] dout_r;
    logic dout_oe_n_r;
    logic irq_oe_n_r;
    logic [3:0] rx_pop_r;
    logic [3:0] tx_push_r;
    logic [7:0] tx_data_r;
    bia_pkg::bia_state_t st_r;
    bia_pkg::bia_state_t st_nxt;

    logic [17:0][7:0] bids;

    bia_bid_form u_bids (
        .src(src),
        .mask0(mask0_r),
        .mask1(mask1_r),
        .prog0(prog0_r),
        .prog1(prog1_r),
        .cten(cten_r),
        .lvl(lvl_r),
        .bids(bids)
    );

    // full 8-bit maximum: channel bits break ties in favour of the higher channel
    logic [7:0] win;
    always_comb begin
        win = 8'h00;
        for (int i = 0; i < bia_pkg::NSRC; i++) begin
            win = bid_max(win, bids[i]);
        end
    end

    wire logic [5:0] thr = icw_r[7:bia_pkg::ICW_THR_LSB];
    wire logic irq_req = win[7:2] > thr;

    // bus cycle decode
    wire logic rd_act = ~s_bus.cen_n & ~s_bus.rd_n;
    wire logic wr_act = ~s_bus.cen_n & ~s_bus.wr_n;
    wire logic ia_act = ~s_bus.iack_n;
    wire logic idle = st_r == bia_pkg::ST_IDLE;
    wire logic ia_start = idle & ia_act;
    wire logic rd_start = idle & ~ia_act & rd_act;
    wire logic wr_start = idle & ~ia_act & ~rd_act & wr_act;
    wire logic wr_end = (st_r == bia_pkg::ST_WRITE) & ~wr_act;
    wire logic upd_cmd = wr_end & (addr_r == bia_pkg::OFF_UPDATE);
    wire logic cap_en = ia_start | upd_cmd;
    wire logic [7:0] cir_nxt = cap_en ? win : cir_r;

    // views decoded from the captured bid; the vector uses the live winning bid
    wire logic cir_is_rx = cir_r[3:2] == bia_pkg::ID_RX;
    wire logic cir_is_tx = cir_r[3:2] == bia_pkg::ID_TX;
    wire logic [1:0] cir_ch = cir_r[1:0];
    wire logic [7:0] gbcnt = cir_is_rx ? {6'h00, cir_r[6:5]} :
                             cir_is_tx ? {5'h00, cir_r[6:4]} : 8'h00;
    wire logic [7:0] gchan = {6'h00, cir_ch};
    wire logic [7:0] grx = cir_is_rx ? rx_data[cir_ch] : 8'h00;
    wire logic vec_on = icw_r[1:0] != bia_pkg::VEC_NONE;
    wire logic [7:0] vec_out = vec_mod(ivec_r, icw_r[1:0], win);

    logic [7:0] rd_mux;
    always_comb begin
        case (s_bus.addr)
            bia_pkg::OFF_CIR: rd_mux = cir_r;
            bia_pkg::OFF_ICW: rd_mux = icw_r;
            bia_pkg::OFF_IVEC: rd_mux = ivec_r;
            bia_pkg::OFF_MASK0: rd_mux = mask0_r;
            bia_pkg::OFF_MASK1: rd_mux = mask1_r;
            bia_pkg::OFF_PROG0: rd_mux = prog0_r;
            bia_pkg::OFF_PROG1: rd_mux = prog1_r;
            bia_pkg::OFF_CTEN: rd_mux = {6'h00, cten_r};
            bia_pkg::OFF_GBCNT: rd_mux = gbcnt;
            bia_pkg::OFF_GCHAN: rd_mux = gchan;
            bia_pkg::OFF_GRX: rd_mux = grx;
            default: rd_mux = (s_bus.addr[5:2] == bia_pkg::OFF_LVL0[5:2]) ?
                              lvl_r[s_bus.addr[1:0]] : 8'h00;
        endcase
    end

    always_comb begin
        case (st_r)
            bia_pkg::ST_IDLE: begin
                if (ia_start) begin
                    st_nxt = bia_pkg::ST_IACK;
                end else if (rd_start) begin
                    st_nxt = bia_pkg::ST_READ;
                end else if (wr_start) begin
                    st_nxt = bia_pkg::ST_WRITE;
                end else begin
                    st_nxt = bia_pkg::ST_IDLE;
                end
            end
            bia_pkg::ST_READ: st_nxt = rd_act ? bia_pkg::ST_READ : bia_pkg::ST_IDLE;
            bia_pkg::ST_WRITE: st_nxt = wr_act ? bia_pkg::ST_WRITE : bia_pkg::ST_IDLE;
            bia_pkg::ST_IACK: st_nxt = ia_act ? bia_pkg::ST_IACK : bia_pkg::ST_IDLE;
            default: st_nxt = bia_pkg::ST_IDLE;
        endcase
    end

    wire logic wr_lvl = wr_end & (addr_r[5:2] == bia_pkg::OFF_LVL0[5:2]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= bia_pkg::ST_IDLE;
            addr_r <= 6'h00;
            wdat_r <= 8'h00;
            cir_r <= bia_pkg::CIR_RST;
        end else begin
            st_r <= st_nxt;
            addr_r <= (rd_start | wr_start) ? s_bus.addr : addr_r;
            wdat_r <= ((st_r == bia_pkg::ST_WRITE) & wr_act) ? s_bus.data : wdat_r;
            cir_r <= cir_nxt;
        end
    end

    // configuration registers written at the trailing edge of a write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            icw_r <= bia_pkg::ICW_RST;
            ivec_r <= bia_pkg::IVEC_RST;
            mask0_r <= bia_pkg::MASK_RST;
            mask1_r <= bia_pkg::MASK_RST;
            prog0_r <= bia_pkg::PROG_RST;
            prog1_r <= bia_pkg::PROG_RST;
            cten_r <= bia_pkg::CTEN_RST;
            lvl_r <= {4{bia_pkg::LVL_RST}};
        end else if (wr_end) begin
            icw_r <= (addr_r == bia_pkg::OFF_ICW) ? wdat_r : icw_r;
            ivec_r <= (addr_r == bia_pkg::OFF_IVEC) ? wdat_r : ivec_r;
            mask0_r <= (addr_r == bia_pkg::OFF_MASK0) ? wdat_r : mask0_r;
            mask1_r <= (addr_r == bia_pkg::OFF_MASK1) ? wdat_r : mask1_r;
            prog0_r <= (addr_r == bia_pkg::OFF_PROG0) ? wdat_r : prog0_r;
            prog1_r <= (addr_r == bia_pkg::OFF_PROG1) ? wdat_r : prog1_r;
            cten_r <= (addr_r == bia_pkg::OFF_CTEN) ? wdat_r[1:0] : cten_r;
            if (wr_lvl) begin
                lvl_r[addr_r[1:0]] <= {1'b0, wdat_r[6:4], 1'b0, wdat_r[2:0]};
            end
        end
    end

    // pin-facing outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dout_r <= 8'h00;
            dout_oe_n_r <= 1'b1;
            irq_oe_n_r <= 1'b1;
            rx_pop_r <= 4'h0;
            tx_push_r <= 4'h0;
            tx_data_r <= 8'h00;
        end else begin
            irq_oe_n_r <= ~irq_req;
            rx_pop_r <= (rd_start & (s_bus.addr == bia_pkg::OFF_GRX) & cir_is_rx) ?
                        ch_onehot(cir_ch) : 4'h0;
            tx_push_r <= (wr_end & (addr_r == bia_pkg::OFF_GTX) & cir_is_tx) ?
                         ch_onehot(cir_ch) : 4'h0;
            tx_data_r <= wr_end ? wdat_r : tx_data_r;
            if (ia_start) begin
                dout_r <= vec_out;
                dout_oe_n_r <= ~vec_on;
            end else if (rd_start) begin
                dout_r <= rd_mux;
                dout_oe_n_r <= 1'b0;
            end else if (st_nxt == bia_pkg::ST_IDLE) begin
                dout_oe_n_r <= 1'b1;
            end
        end
    end

    assign data_out = dout_r;
    assign data_oe_n = dout_oe_n_r;
    assign interrupt_request_n_out = 1'b0;
    assign interrupt_request_n_oe_n = irq_oe_n_r;
    assign rx_pop = rx_pop_r;
    assign tx_push = tx_push_r;
    assign tx_data = tx_data_r;
    assign current_interrupt_capture = cir_r;

    // helper terms for the vector and arbitration checks below
    logic dout_out_ok;
    logic win_ge_all;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_upd_write;
        (st_r == bia_pkg::ST_WRITE) ##1 upd_cmd;
    endsequence

    sequence s_ack_begin;
        idle && ia_act;
    endsequence

    chk_irq_assert: assert property (win[7:2] > thr |=> !irq_oe_n_r)
        else $error("request not driven while winner above threshold");
    chk_irq_release: assert property (win[7:2] <= thr |=> irq_oe_n_r)
        else $error("request driven while no bid above threshold");
    chk_thr_ignores_ch: assert property ((win[7:2] == thr) && (win[1:0] != 2'b00)
                                         |=> irq_oe_n_r)
        else $error("channel bits took part in threshold compare");
    chk_cap_hold: assert property (!ia_start && !upd_cmd |=> $stable(cir_r))
        else $error("capture changed without acknowledge or command");
    chk_cap_ack: assert property (s_ack_begin |=> cir_r == $past(win) ##0
                                  st_r == bia_pkg::ST_IACK)
        else $error("acknowledge did not capture winning bid");
    chk_update_cmd: assert property (s_upd_write |=> cir_r == $past(win))
        else $error("refresh command did not capture winning bid");
    chk_ack_vector: assert property ((s_ack_begin and vec_on) |=> !dout_oe_n_r &&
                                     dout_out_ok ##1 (!dout_oe_n_r || !ia_act))
        else $error("vector not driven during acknowledge");
    chk_gchan_view: assert property (rd_start && s_bus.addr == bia_pkg::OFF_GCHAN
                                     |=> dout_r == {6'h00, $past(cir_r[1:0])})
        else $error("global channel read does not match capture");
    chk_grx_route: assert property (rd_start && s_bus.addr == bia_pkg::OFF_GRX &&
                                    cir_is_rx |=> rx_pop == ch_onehot($past(cir_r[1:0])))
        else $error("global receive read went to the wrong channel");
    chk_reset_cap: assert property ($fell(rst) |-> cir_r == bia_pkg::CIR_RST)
        else $error("capture not cleared by reset");
    chk_win_max: assert property (win_ge_all)
        else $error("winner smaller than some bid");

    always_comb begin
        win_ge_all = 1'b1;
        for (int i = 0; i < bia_pkg::NSRC; i++) begin
            win_ge_all = win_ge_all & (win >= bids[i]);
        end
        dout_out_ok = dout_r == vec_mod(ivec_r, icw_r[1:0], cir_r);
    end
endmodule : bia_top
`default_nettype wire

// *** verif/bia_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module bia_host (
    input wire logic core_clk,
    output logic cen_n,
    output logic rd_n,
    output logic wr_n,
    output logic iack_n,
    output logic [5:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    int slow = 0;

    initial begin
        cen_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        iack_n = 1'b1;
        addr = 6'h00;
        data_in = 8'h00;
    end

    // k: 0 write, 1 read, 2 acknowledge; write strobes stay low 5+slow cycles, others until the answer is seen or 12 more cycles pass
    task automatic cyc(input int k, input logic [5:0] a, input logic [7:0] v,
                       output logic [7:0] d, output logic drv);
        @(posedge core_clk);
        addr <= a;
        data_in <= v;
        cen_n <= (k == 2);
        rd_n <= (k != 1);
        wr_n <= (k != 0);
        iack_n <= (k != 2);
        d = 8'hxx;
        drv = 1'b0;
        repeat (5 + slow) @(posedge core_clk);
        for (int n = 0; n < 12 && k != 0 && !drv; n++) begin
            if (data_oe_n === 1'b0) begin
                d = data_out;
                drv = 1'b1;
            end else begin
                @(posedge core_clk);
            end
        end
        cen_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        iack_n <= 1'b1;
        // released lines stop showing the old value after a short hold
        @(posedge core_clk);
        addr <= ~a;
        data_in <= ~v;
        repeat (7) @(posedge core_clk);
    endtask : cyc

    // service routine without acknowledge starts by refreshing the capture
    task automatic refresh;
        logic [7:0] d;
        logic v;
        cyc(0, bia_pkg::OFF_UPDATE, 8'h00, d, v);
    endtask : refresh
endmodule : bia_host
`default_nettype wire

// *** verif/test_bidding_interrupt_arbiter.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_bidding_interrupt_arbiter;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cen_n, rd_n, wr_n, iack_n, data_oe_n, irq_out, irq_oe_n, drv;
    logic [5:0] addr;
    logic [7:0] data_in, data_out, cap, tx_data, d, e, v, txd;
    logic [3:0] rx_pop, tx_push;
    logic [3:0] pops = 4'h0;
    logic [3:0] pushes = 4'h0;
    logic clr_st = 1'b0;
    logic [3:0][7:0] rx_data = '0;
    bia_pkg::bia_src_t src = '0;
    logic [7:0] cfg [11];
    logic [7:0] rst_val [9] = '{8'h00, 8'hfc, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int errors = 0;
    int n_tests = 0;
    int w;

    always #2 core_clk = ~core_clk;

    bia_host bia_host_i (.core_clk(core_clk), .cen_n(cen_n), .rd_n(rd_n), .wr_n(wr_n),
        .iack_n(iack_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n));

    bia_top bia_top_i (.core_clk(core_clk), .rst(rst), .cen_n(cen_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .interrupt_acknowledge_n(iack_n),
        .interrupt_request_n_out(irq_out), .interrupt_request_n_oe_n(irq_oe_n),
        .src(src), .rx_data(rx_data), .rx_pop(rx_pop), .tx_push(tx_push),
        .tx_data(tx_data), .current_interrupt_capture(cap));

    // collects fifo strobes so stray or wrong-channel pulses show up
    always @(posedge core_clk) begin
        pops <= clr_st ? 4'h0 : pops | rx_pop;
        pushes <= clr_st ? 4'h0 : pushes | tx_push;
        if (tx_push !== 4'h0) txd <= tx_data;
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] x);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("ERROR %0t: byte %h, expected %h", $time, g, x);
        end
    endtask : chk8

    task automatic chk1(input logic g, input logic x);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("ERROR %0t: flag %b, expected %b", $time, g, x);
        end
    endtask : chk1

    task automatic stop_test;
        $display("comparisons %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic wr(input logic [5:0] a, input logic [7:0] x);
        bia_host_i.cyc(0, a, x, d, drv);
    endtask : wr

    task automatic rd(input logic [5:0] a);
        bia_host_i.cyc(1, a, 8'h00, d, drv);
    endtask : rd

    task automatic new_src;
        bia_pkg::bia_src_t s;
        s.rx_error = 4'($urandom);
        s.brk = 4'($urandom);
        s.cos = 4'($urandom);
        s.ct_done = 2'($urandom);
        for (int k = 0; k < 4; k++) begin
            s.rx_count[k] = 4'($urandom % 9);
            s.tx_free[k] = 4'($urandom % 9);
        end
        @(posedge core_clk);
        src <= s;
        rx_data <= 32'($urandom);
        repeat (4) @(posedge core_clk);
    endtask : new_src

    // reference arbiter: greatest enabled bid, zero when nothing bids
    function automatic int win();
        int w0, b, m, p;
        w0 = 0;
        for (int k = 0; k < 4; k++) begin
            m = int'(cfg[2 + k / 2]) >> (4 * (k % 2));
            p = int'(cfg[4 + k / 2]);
            b = 140 + k + 16 * int'(src.rx_error[k]);
            b = b + 32 * (src.rx_count[k] >= 8 ? 3 : int'(src.rx_count[k]) / 2);
            if (m % 2 == 1 && src.rx_count[k] > cfg[7 + k] % 8 && b > w0) w0 = b;
            b = 8 + k + 16 * (src.tx_free[k] >= 8 ? 7 : int'(src.tx_free[k]));
            if (m / 2 % 2 == 1 && src.tx_free[k] > cfg[7 + k] / 16 % 8 && b > w0) w0 = b;
            b = p / 32 * 32 + 16 + k;
            if (m / 4 % 2 == 1 && src.brk[k] && b > w0) w0 = b;
            b = p / 4 % 8 * 32 + 4 + k;
            if (m / 8 % 2 == 1 && src.cos[k] && b > w0) w0 = b;
        end
        for (int k = 0; k < 2; k++) begin
            b = int'(cfg[4 + k]) % 4 * 64 + 20 + 2 * k;
            if (cfg[6][k] && src.ct_done[k] && b > w0) w0 = b;
        end
        return w0;
    endfunction : win

    initial begin
        repeat (50000) @(posedge core_clk);
        $display("ERROR %0t: watchdog expired", $time);
        errors++;
        stop_test;
    end

    initial begin
        void'($urandom(26484));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk8(cap, 8'h00);
        chk1(irq_oe_n, 1'b1);
        for (int k = 0; k < 9; k++) begin
            rd(bia_pkg::OFF_CIR + 6'(k));
            chk8(d, rst_val[k]);
        end
        rd(6'h05);
        chk8(d, 8'h00);
        new_src;
        chk1(irq_oe_n, 1'b1);
        w = 0;
        for (int i = 0; i < 40; i++) begin
            bia_host_i.slow = i % 3;
            for (int k = 0; k < 11; k++) begin
                cfg[k] = 8'($urandom);
                if (k > 6) cfg[k] = cfg[k] & 8'h33;
                wr(bia_pkg::OFF_ICW + 6'(k), cfg[k]);
            end
            new_src;
            chk1(irq_oe_n, win() / 4 > cfg[0] / 4 ? 1'b0 : 1'b1);
            chk1(irq_out, 1'b0);
            wr(bia_pkg::OFF_CIR, 8'hff);
            chk8(cap, 8'(w));
            w = win();
            e = 8'(w);
            if (i % 2 == 1) begin
                bia_host_i.refresh;
            end else begin
                bia_host_i.cyc(2, 6'h00, 8'h00, d, drv);
                v = cfg[0][1] ? {cfg[1][7:5], e[4:0]} : cfg[0][0] ? {cfg[1][7:2], e[1:0]} : cfg[1];
                chk1(drv, cfg[0][1:0] != 2'b11);
                if (drv) chk8(d, v);
            end
            chk8(cap, e);
            rd(bia_pkg::OFF_GBCNT);
            v = e[3:2] == 2'b11 ? {6'h00, e[6:5]} : e[3:2] == 2'b10 ? {5'h00, e[6:4]} : 8'h00;
            chk8(d, v);
            rd(bia_pkg::OFF_GCHAN);
            chk8(d, {6'h00, e[1:0]});
            @(negedge core_clk);
            clr_st = 1'b1;
            @(negedge core_clk);
            clr_st = 1'b0;
            rd(bia_pkg::OFF_GRX);
            chk8(d, e[3:2] == 2'b11 ? rx_data[e[1:0]] : 8'h00);
            chk8(8'(pops), e[3:2] == 2'b11 ? 8'(4'h1 << e[1:0]) : 8'h00);
            wr(bia_pkg::OFF_GTX, cfg[1]);
            chk8(8'(pushes), e[3:2] == 2'b10 ? 8'(4'h1 << e[1:0]) : 8'h00);
            if (e[3:2] == 2'b10) chk8(txd, cfg[1]);
        end
        stop_test;
    end
endmodule : test_bidding_interrupt_arbiter
`default_nettype wire
